// ---- wfd_defs.svh ----
// register offsets, field positions, counts and crc constants for the wake detector
`ifndef WFD_DEFS_SVH
`define WFD_DEFS_SVH
// ----------------------------------------------------------------------------
// register byte addresses (avalon word offsets x4)
// ----------------------------------------------------------------------------
`define WFD_ADDR_CTRL      6'h00
`define WFD_ADDR_STAADR_LO 6'h04
`define WFD_ADDR_STAADR_HI 6'h08
`define WFD_ADDR_MASK0     6'h10
`define WFD_ADDR_CMD       6'h20
`define WFD_ADDR_OFFSET    6'h24
`define WFD_ADDR_CRC01     6'h28
`define WFD_ADDR_CRC23     6'h2C
// ----------------------------------------------------------------------------
// wake_control_status and filter command fields
// ----------------------------------------------------------------------------
`define WFD_BIT_RW_EN     0
`define WFD_BIT_PW_EN     1
`define WFD_BIT_RW_RX     2
`define WFD_BIT_PW_RX     3
`define WFD_BIT_SIG_PEV   4
`define WFD_BIT_LOWPOWER  5
`define WFD_CMD_EN_BIT    0
`define WFD_CMD_MCAST_BIT 3
// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define WFD_NUM_FILT      4
`define WFD_SYNC_BYTES    3'h6
`define WFD_ADDR_REPS     5'h10
`define WFD_HDR_BYTES     8'h0C
`define WFD_CRC_INIT      16'hFFFF
`define WFD_CRC_POLY      16'h8005
`endif

// ---- wfd_pkg.sv ----
// types shared by the wake frame detector
package wfd_pkg;
    typedef enum logic [1:0] {
        WFD_SCAN  = 2'b00,
        WFD_SYNC  = 2'b01,
        WFD_REPS  = 2'b11
    } wfd_rw_state_type;
endpackage

// ---- wfd_crc_filter.sv ----
// one pattern filter: masked crc-16 over selected frame bytes
`timescale 1ns/10ps
`include "wfd_defs.svh"
module wfd_crc_filter (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        sof_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic [10:0] pos_i,
    input  wire logic [30:0] mask_i,
    input  wire logic [7:0]  offset_i,
    output logic      [15:0] crc_o
);
    // ------------------------------------------------------------------------
    // crc step
    // ------------------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ `WFD_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic [10:0] rel;
    logic        sel;

    always_comb begin
        rel = pos_i - {3'h0, offset_i};
        sel = (pos_i >= {3'h0, offset_i}) && (rel < 11'h01F) && mask_i[rel[4:0]];
        crc_next = crc_reg;
        if (sof_i) begin
            crc_next = `WFD_CRC_INIT;
        end else if (byte_valid_i && sel) begin
            crc_next = crc16_byte(crc_reg, byte_i);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            crc_reg <= 16'hFFFF;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc_o = crc_reg;
endmodule // wfd_crc_filter

// ---- wfd_remote_scan.sv ----
// remote wake scanner: sync stream then sixteen address copies
`timescale 1ns/10ps
`include "wfd_defs.svh"
module wfd_remote_scan (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        sof_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic [10:0] pos_i,
    input  wire logic [47:0] station_addr_i,
    output logic             found_o
);
    wfd_pkg::wfd_rw_state_type state_reg, state_next;
    logic [2:0] ff_cnt_reg, ff_cnt_next;
    logic [2:0] byte_idx_reg, byte_idx_next;
    logic [4:0] rep_reg, rep_next;
    logic       found_reg, found_next;
    logic [7:0] exp_byte;

    always_comb begin
        // address goes out first byte on the wire = bits 7:0
        exp_byte = station_addr_i[8*byte_idx_reg +: 8];
        state_next = state_reg;
        ff_cnt_next = ff_cnt_reg;
        byte_idx_next = byte_idx_reg;
        rep_next = rep_reg;
        found_next = found_reg;
        if (sof_i) begin
            state_next = wfd_pkg::WFD_SCAN;
            ff_cnt_next = 3'h0;
            byte_idx_next = 3'h0;
            rep_next = 5'h00;
            found_next = 1'b0;
        end else if (byte_valid_i && pos_i >= 11'(`WFD_HDR_BYTES) && !found_reg) begin
            unique case (state_reg)
                wfd_pkg::WFD_SCAN, wfd_pkg::WFD_SYNC: begin
                    if (byte_i == 8'hFF) begin
                        ff_cnt_next = (ff_cnt_reg == `WFD_SYNC_BYTES) ? ff_cnt_reg : ff_cnt_reg + 3'h1;
                        state_next = wfd_pkg::WFD_SYNC;
                        // extra ff bytes keep the sync open; addr may start with ff
                        if (ff_cnt_reg == `WFD_SYNC_BYTES && exp_byte == 8'hFF
                            && station_addr_i == 48'hFFFF_FFFF_FFFF) begin
                            state_next = wfd_pkg::WFD_SYNC;
                        end
                    end else if (ff_cnt_reg == `WFD_SYNC_BYTES && byte_i == station_addr_i[7:0]) begin
                        state_next = wfd_pkg::WFD_REPS;
                        byte_idx_next = 3'h1;
                        rep_next = 5'h00;
                    end else begin
                        state_next = wfd_pkg::WFD_SCAN;
                        ff_cnt_next = 3'h0;
                    end
                end
                wfd_pkg::WFD_REPS: begin
                    if (byte_i == exp_byte) begin
                        if (byte_idx_reg == 3'h5) begin
                            byte_idx_next = 3'h0;
                            rep_next = rep_reg + 5'h01;
                            if (rep_reg + 5'h01 == `WFD_ADDR_REPS) begin
                                found_next = 1'b1;
                                state_next = wfd_pkg::WFD_SCAN;
                            end
                        end else begin
                            byte_idx_next = byte_idx_reg + 3'h1;
                        end
                    end else begin
                        state_next = (byte_i == 8'hFF) ? wfd_pkg::WFD_SYNC : wfd_pkg::WFD_SCAN;
                        ff_cnt_next = (byte_i == 8'hFF) ? 3'h1 : 3'h0;
                        byte_idx_next = 3'h0;
                        rep_next = 5'h00;
                    end
                end
                default: begin
                    state_next = wfd_pkg::WFD_SCAN;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= wfd_pkg::WFD_SCAN;
            ff_cnt_reg <= 3'h0;
            byte_idx_reg <= 3'h0;
            rep_reg <= 5'h00;
            found_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ff_cnt_reg <= ff_cnt_next;
            byte_idx_reg <= byte_idx_next;
            rep_reg <= rep_next;
            found_reg <= found_next;
        end
    end

    assign found_o = found_reg;
endmodule // wfd_remote_scan

// ---- wfd_wake_frame_detector.sv ----
// wake frame detector top: avalon registers, filters, remote wake scan
`timescale 1ns/10ps
`include "wfd_defs.svh"
module wfd_wake_frame_detector (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // receive path
    input  wire logic        rx_sof_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_eof_i,
    input  wire logic        rx_good_i,
    input  wire logic        low_power_i,
    output logic             rx_suspend_o,
    output logic             host_irq_o,
    output logic             power_event_output_o
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [5:0]  ctrl_reg, ctrl_next;
    logic [47:0] sta_reg, sta_next;
    // one row per filter; bit 31 is not stored
    logic [30:0] mask_reg [`WFD_NUM_FILT];
    logic [30:0] mask_next [`WFD_NUM_FILT];
    logic [15:0] cmd_reg, cmd_next;
    logic [31:0] filter_pattern_offset_reg, filter_pattern_offset_next;
    logic [63:0] filter_pattern_crc_reg, filter_pattern_crc_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    // low_power_i comes from another domain
    logic [1:0]  lp_sync_reg;

    // ------------------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------------------
    logic [10:0] pos_reg, pos_next;
    logic [47:0] da_reg, da_next;
    logic        in_frame_reg, in_frame_next;
    logic        rw_hit, pw_hit;
    logic [15:0] crc_w [`WFD_NUM_FILT];
    logic        rw_found;
    logic        rw_armed, pw_armed;
    logic        da_own, da_bcast, da_mcast;
    logic [3:0]  filt_pass;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // low power level from outside, two stage sync
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lp_sync_reg <= 2'b00;
        end else begin
            lp_sync_reg <= {lp_sync_reg[0], low_power_i};
        end
    end

    // low power arms both, whatever the enables say
    assign rw_armed = ctrl_reg[`WFD_BIT_RW_EN] | lp_sync_reg[1];
    assign pw_armed = ctrl_reg[`WFD_BIT_PW_EN] | lp_sync_reg[1];

    // ------------------------------------------------------------------------
    // filters and scanner
    // ------------------------------------------------------------------------
    // every filter sees every byte; its mask picks
    for (genvar g = 0; g < `WFD_NUM_FILT; g++) begin : g_filt
        wfd_crc_filter u_filt (
            .clock_i      (clock_i),
            .rst_i        (rst_i),
            .sof_i        (rx_sof_i),
            .byte_valid_i (rx_valid_i),
            .byte_i       (rx_data_i),
            .pos_i        (pos_reg),
            .mask_i       (mask_reg[g]),
            .offset_i     (filter_pattern_offset_reg[8*g +: 8]),
            .crc_o        (crc_w[g])
        );
    end

    // found only counts once eof says the frame was good
    wfd_remote_scan u_scan (
        .clock_i        (clock_i),
        .rst_i          (rst_i),
        .sof_i          (rx_sof_i),
        .byte_valid_i   (rx_valid_i),
        .byte_i         (rx_data_i),
        .pos_i          (pos_reg),
        .station_addr_i (sta_reg),
        .found_o        (rw_found)
    );

    always_comb begin
        // da byte 0 first on wire sits in bits 7:0
        da_own   = (da_reg == sta_reg);
        da_bcast = (da_reg == 48'hFFFF_FFFF_FFFF);
        da_mcast = da_reg[0] & ~da_bcast;
        for (int i = 0; i < `WFD_NUM_FILT; i++) begin
            // filters only see own-address or multicast by type bit
            filt_pass[i] = cmd_reg[4*i + `WFD_CMD_EN_BIT]
                & (cmd_reg[4*i + `WFD_CMD_MCAST_BIT] ? da_mcast : da_own)
                & (crc_w[i] == filter_pattern_crc_reg[16*i +: 16]);
        end
        // verdicts only at a good end of frame
        pw_hit = rx_eof_i && in_frame_reg && rx_good_i && pw_armed && (|filt_pass);
        rw_hit = rx_eof_i && in_frame_reg && rx_good_i && rw_armed && rw_found
            && (da_own || da_bcast || da_mcast);
        pos_next = pos_reg;
        da_next = da_reg;
        in_frame_next = in_frame_reg;
        if (rx_sof_i) begin
            pos_next = 11'h000;
            in_frame_next = 1'b1;
            // clear so a runt frame cannot reuse an old address
            da_next = 48'h0000_0000_0000;
        end else if (rx_valid_i) begin
            if (pos_reg < 11'h006) begin
                da_next[8*pos_reg[2:0] +: 8] = rx_data_i;
            end
            // saturate: long frames stop advancing, no wrap into header
            if (pos_reg != 11'h7FF) begin
                pos_next = pos_reg + 11'h001;
            end
        end
        // eof closes even a cut frame
        if (rx_eof_i) begin
            in_frame_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // avalon slave: one wait cycle, answer registered
    // ------------------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        sta_next = sta_reg;
        mask_next = mask_reg;
        cmd_next = cmd_reg;
        filter_pattern_offset_next = filter_pattern_offset_reg;
        filter_pattern_crc_next = filter_pattern_crc_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        // write lands where waitrequest is seen low
        if (avs_read_i || avs_write_i) begin
            ack_next = ~ack_reg;
            if (avs_write_i && ack_reg) begin
                unique case (avs_address_i)
                    `WFD_ADDR_CTRL: begin
                        // control bits live in byte lane 0
                        ctrl_next[`WFD_BIT_RW_EN] = avs_byteenable_i[0]
                            ? avs_writedata_i[`WFD_BIT_RW_EN] : ctrl_reg[`WFD_BIT_RW_EN];
                        ctrl_next[`WFD_BIT_PW_EN] = avs_byteenable_i[0]
                            ? avs_writedata_i[`WFD_BIT_PW_EN] : ctrl_reg[`WFD_BIT_PW_EN];
                        ctrl_next[`WFD_BIT_SIG_PEV] = avs_byteenable_i[0]
                            ? avs_writedata_i[`WFD_BIT_SIG_PEV] : ctrl_reg[`WFD_BIT_SIG_PEV];
                        // write one clears received bits
                        if (avs_byteenable_i[0] && avs_writedata_i[`WFD_BIT_RW_RX]) begin
                            ctrl_next[`WFD_BIT_RW_RX] = 1'b0;
                        end
                        if (avs_byteenable_i[0] && avs_writedata_i[`WFD_BIT_PW_RX]) begin
                            ctrl_next[`WFD_BIT_PW_RX] = 1'b0;
                        end
                    end
                    `WFD_ADDR_STAADR_LO: sta_next[31:0] =
                        merge_be(sta_reg[31:0], avs_writedata_i, avs_byteenable_i);
                    `WFD_ADDR_STAADR_HI: sta_next[47:32] =
                        16'(merge_be({16'h0000, sta_reg[47:32]}, avs_writedata_i,
                                     avs_byteenable_i));
                    `WFD_ADDR_CMD: cmd_next =
                        16'(merge_be({16'h0000, cmd_reg}, avs_writedata_i, avs_byteenable_i))
                        & 16'h9999;
                    `WFD_ADDR_OFFSET: filter_pattern_offset_next =
                        merge_be(filter_pattern_offset_reg, avs_writedata_i, avs_byteenable_i);
                    `WFD_ADDR_CRC01: filter_pattern_crc_next[31:0] =
                        merge_be(filter_pattern_crc_reg[31:0], avs_writedata_i, avs_byteenable_i);
                    `WFD_ADDR_CRC23: filter_pattern_crc_next[63:32] =
                        merge_be(filter_pattern_crc_reg[63:32], avs_writedata_i, avs_byteenable_i);
                    default: begin
                        for (int i = 0; i < `WFD_NUM_FILT; i++) begin
                            if (avs_address_i == `WFD_ADDR_MASK0 + 6'(4 * i)) begin
                                // bit 31 forced zero
                                mask_next[i] = 31'(merge_be({1'b0, mask_reg[i]},
                                    avs_writedata_i, avs_byteenable_i));
                            end
                        end
                    end
                endcase
            end else if (avs_read_i && !ack_reg) begin
                unique case (avs_address_i)
                    `WFD_ADDR_CTRL:      rdata_next = {26'h000_0000, ctrl_reg};
                    `WFD_ADDR_STAADR_LO: rdata_next = sta_reg[31:0];
                    `WFD_ADDR_STAADR_HI: rdata_next = {16'h0000, sta_reg[47:32]};
                    `WFD_ADDR_CMD:       rdata_next = {16'h0000, cmd_reg};
                    `WFD_ADDR_OFFSET:    rdata_next = filter_pattern_offset_reg;
                    `WFD_ADDR_CRC01:     rdata_next = filter_pattern_crc_reg[31:0];
                    `WFD_ADDR_CRC23:     rdata_next = filter_pattern_crc_reg[63:32];
                    default: begin
                        rdata_next = 32'h0000_0000;
                        for (int i = 0; i < `WFD_NUM_FILT; i++) begin
                            if (avs_address_i == `WFD_ADDR_MASK0 + 6'(4 * i)) begin
                                rdata_next = {1'b0, mask_reg[i]};
                            end
                        end
                    end
                endcase
            end
        end
        // hardware set wins over software clear
        if (rw_hit) begin
            ctrl_next[`WFD_BIT_RW_RX] = 1'b1;
        end
        if (pw_hit) begin
            ctrl_next[`WFD_BIT_PW_RX] = 1'b1;
        end
        // software sees the synced level, one cycle late
        ctrl_next[`WFD_BIT_LOWPOWER] = lp_sync_reg[1];
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= 6'h00;
            sta_reg <= 48'h0000_0000_0000;
            for (int i = 0; i < `WFD_NUM_FILT; i++) begin
                mask_reg[i] <= 31'h0000_0000;
            end
            cmd_reg <= 16'h0000;
            // offsets start past both address fields
            filter_pattern_offset_reg <= 32'h0C0C_0C0C;
            filter_pattern_crc_reg <= 64'h0000_0000_0000_0000;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            pos_reg <= 11'h000;
            da_reg <= 48'h0000_0000_0000;
            in_frame_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            sta_reg <= sta_next;
            mask_reg <= mask_next;
            cmd_reg <= cmd_next;
            filter_pattern_offset_reg <= filter_pattern_offset_next;
            filter_pattern_crc_reg <= filter_pattern_crc_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            pos_reg <= pos_next;
            da_reg <= da_next;
            in_frame_reg <= in_frame_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // combinational: answer seen the cycle it stands
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign avs_readdata_o = rdata_reg;
    assign rx_suspend_o = rw_armed | pw_armed;
    // received bits steer to irq or power event by the select bit
    assign host_irq_o = (ctrl_reg[`WFD_BIT_RW_RX] | ctrl_reg[`WFD_BIT_PW_RX])
        & ~ctrl_reg[`WFD_BIT_SIG_PEV];
    assign power_event_output_o = (ctrl_reg[`WFD_BIT_RW_RX] | ctrl_reg[`WFD_BIT_PW_RX])
        & ctrl_reg[`WFD_BIT_SIG_PEV];
endmodule // wfd_wake_frame_detector

// ---- wfd_checker.sv ----
// port assertions for the wake frame detector
`timescale 1ns/10ps
module wfd_checker (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic        rx_eof_i,
    input  wire logic        rx_good_i,
    input  wire logic        low_power_i,
    input  wire logic        rx_suspend_o,
    input  wire logic        host_irq_o,
    input  wire logic        power_event_output_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic ev = host_irq_o | power_event_output_o;
    AST_WAIT: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1
        !avs_waitrequest_o) else $error("bus answer late");
    AST_RESET: assert property (disable iff (1'b0) rst_i |-> !ev && !rx_suspend_o)
        else $error("outputs active in reset");
    AST_ONE_SIGNAL: assert property (!(host_irq_o && power_event_output_o))
        else $error("both signals raised");
    AST_AT_EOF: assert property ($rose(ev) |-> $past(rx_eof_i && rx_good_i, 2) ||
        $past(rx_eof_i && rx_good_i, 3) || $past(rx_eof_i && rx_good_i)) else $error("no eof");
    AST_HOLD: assert property (ev && !avs_write_i |=> ev) else $error("status lost");
    AST_LOW_POWER: assert property (low_power_i [*4] |-> rx_suspend_o)
        else $error("low power not armed");
    AST_RDATA: assert property (!avs_read_i ##1 !avs_read_i |-> $stable(avs_readdata_o))
        else $error("read data moved");
    AST_RESUME: assert property ($fell(rx_suspend_o) |-> $past(avs_write_i) ||
        !$past(low_power_i, 2)) else $error("resume without write");
    cover property ($rose(host_irq_o));
    cover property ($rose(power_event_output_o));
    cover property ($fell(rx_suspend_o));
endmodule // wfd_checker
bind wfd_wake_frame_detector wfd_checker wfd_checker_i (.clock_i, .rst_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .rx_eof_i, .rx_good_i, .low_power_i,
    .rx_suspend_o, .host_irq_o, .power_event_output_o);

// ---- wfd_rx_model.sv ----
// receive path model: plays one stored frame byte by byte
`timescale 1ns/10ps
module wfd_rx_model (
    input  wire logic       clock_i,
    output logic            rx_sof_o,
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    output logic            rx_eof_o,
    output logic            rx_good_o
);
    logic [7:0] frm [0:255];
    initial {rx_sof_o, rx_valid_o, rx_data_o, rx_eof_o, rx_good_o} = '0;
    // byte 0 is the first destination byte; gap stretches bytes apart
    task automatic send(input int len, input logic good, input int gap);
        @(posedge clock_i) rx_sof_o <= 1'b1;
        @(posedge clock_i) rx_sof_o <= 1'b0;
        for (int i = 0; i < len; i++) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= frm[i];
            @(posedge clock_i);
            if (gap > 0) begin
                rx_valid_o <= 1'b0;
                rx_data_o <= ~frm[i]; // no stale byte between strobes
                repeat (gap) @(posedge clock_i);
            end
        end
        rx_valid_o <= 1'b0;
        rx_eof_o <= 1'b1;
        rx_good_o <= good;
        @(posedge clock_i) rx_eof_o <= 1'b0;
        rx_good_o <= ~good;
    endtask
endmodule // wfd_rx_model

// ---- wfd_wake_frame_detector_tb.sv ----
// self-checking bench for the wake frame detector
`timescale 1ns/10ps
`include "wfd_defs.svh"
module wfd_wake_frame_detector_tb;
    logic        clock_i, rst_i, rd, wr, lp, sof, vld, eof, good, wreq, susp, irq, pev;
    logic [5:0]  adr;
    logic [7:0]  dat;
    logic [31:0] wd, rdat, q;
    logic [47:0] st = 48'h5544_3322_1100;
    int          num_errors, compares, p;
    wfd_wake_frame_detector wfd_wake_frame_detector_i (.clock_i, .rst_i, .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rx_sof_i(sof), .rx_valid_i(vld),
        .rx_data_i(dat), .rx_eof_i(eof), .rx_good_i(good), .low_power_i(lp),
        .rx_suspend_o(susp), .host_irq_o(irq), .power_event_output_o(pev));
    wfd_rx_model wfd_rx_model_i (.clock_i, .rx_sof_o(sof), .rx_valid_o(vld), .rx_data_o(dat),
        .rx_eof_o(eof), .rx_good_o(good));
    task automatic conclude;
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    // holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        adr <= a;
        rd <= ~w;
        wr <= w;
        wd <= d;
        @(posedge clock_i);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 40) begin
                num_errors++;
                conclude;
            end
            @(posedge clock_i);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic add(input logic [7:0] b);
        wfd_rx_model_i.frm[p] = b;
        p++;
    endtask
    task automatic hdr(input logic [47:0] da);
        p = 0;
        for (int k = 0; k < 12; k++) add(k < 6 ? da[8*k +: 8] : 8'h02);
    endtask
    task automatic reps(input int n);
        repeat (6) add(8'hFF);
        for (int k = 0; k < 6 * n; k++) add(st[8*(k%6) +: 8]);
    endtask
    task automatic fire(input logic g, input int gap, input logic [1:0] e);
        wfd_rx_model_i.send(p, g, gap);
        repeat (4) @(posedge clock_i);
        chk({irq, pev}, e);
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) c = (c << 1) ^ ((c[15] ^ b[i]) ? `WFD_CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic t_regs;
        rdchk(`WFD_ADDR_OFFSET, 32'h0C0C_0C0C);
        rdchk(6'h3C, 32'h0000_0000);
        bus(1'h1, `WFD_ADDR_CMD, 32'hFFFF_FFFF);
        rdchk(`WFD_ADDR_CMD, 32'h0000_9999);
    endtask
    task automatic t_remote;
        bus(1'h1, `WFD_ADDR_STAADR_LO, 32'h3322_1100);
        bus(1'h1, `WFD_ADDR_STAADR_HI, 32'h0000_5544);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0001);
        chk(susp, 1'h1);
        hdr(st); reps(16); fire(1'h1, 0, 2'h2);
        rdchk(`WFD_ADDR_CTRL, 32'h0000_0005);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0015);
        hdr(48'hFFFF_FFFF_FFFF); reps(10); add(8'h00); reps(16); fire(1'h1, 0, 2'h1);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0015);
        hdr(st); reps(15); fire(1'h1, 0, 2'h0);
        hdr(48'h0000_0000_0002); reps(16); fire(1'h1, 0, 2'h0);
        hdr(st); reps(16); fire(1'h0, 0, 2'h0);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0000);
        chk(susp, 1'h0);
    endtask
    task automatic t_pattern;
        logic [15:0] c = crc(crc(`WFD_CRC_INIT, 8'hA5), 8'h3C);
        bus(1'h1, `WFD_ADDR_MASK0, 32'h0000_0003);
        bus(1'h1, `WFD_ADDR_CMD, 32'h0000_0001);
        bus(1'h1, `WFD_ADDR_CRC01, {16'h0000, c});
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0002);
        chk(susp, 1'h1);
        hdr(st); add(8'hA5); add(8'h3C); add(8'h77); fire(1'h1, 2, 2'h2);
        rdchk(`WFD_ADDR_CTRL, 32'h0000_000A);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_000A);
        hdr(st); add(8'hA5); add(8'h3D); fire(1'h1, 0, 2'h0);
        bus(1'h1, `WFD_ADDR_OFFSET, 32'h0C0C_0C0D);
        hdr(st); add(8'h00); add(8'hA5); add(8'h3C); fire(1'h1, 0, 2'h2);
        bus(1'h1, `WFD_ADDR_CTRL, 32'h0000_0008);
        chk({irq, susp}, 2'h0);
    endtask
    task automatic t_lowpower;
        lp <= 1'h1;
        repeat (6) @(posedge clock_i);
        chk(susp, 1'h1);
        rdchk(`WFD_ADDR_CTRL, 32'h0000_0020);
        hdr(st); reps(16); fire(1'h1, 0, 2'h2);
        lp <= 1'h0;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    initial begin
        {rst_i, rd, wr, lp, adr, wd, num_errors, compares, p} = '0;
        rst_i = 1'b1;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs;
        t_remote;
        t_pattern;
        t_lowpower;
        conclude;
    end
endmodule // wfd_wake_frame_detector_tb
